// ==== rtl/nv_ctrl_pkg.sv ====
// constants, register map and state encoding of the nonvolatile byte store
// assumes: an apb slave with 32-bit data and byte addresses
package nv_ctrl_pkg;

	localparam int unsigned MEM_BYTES = 512;
	localparam int unsigned ADDR_BITS = 9;
	localparam int unsigned DATA_BITS = 8;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_ADDR  = 8'h04;
	localparam logic [7:0] OFS_DATA  = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0c;
	localparam logic [7:0] OFS_CLR   = 8'h10;
	localparam logic [7:0] OFS_IEN   = 8'h14;
	localparam logic [7:0] OFS_FLAGS = 8'h18;

	// control register fields
	localparam int unsigned CTRL_READ  = 0;
	localparam int unsigned CTRL_WRITE = 1;
	localparam int unsigned CTRL_ARM   = 2;
	localparam int unsigned CTRL_RIE   = 3;

	// event bits, shared by status, clear and enable
	localparam int unsigned EVT_WRITE_DONE  = 0;
	localparam int unsigned EVT_ARM_EXPIRED = 1;
	localparam int unsigned EVT_READ_DONE   = 2;
	localparam int unsigned EVT_BITS        = 3;

	// flags register: live self-program busy level
	localparam int unsigned FLAG_SPM_BUSY = 0;

	localparam logic [2:0] ARM_CYCLES         = 3'h4;
	localparam logic [2:0] READ_STALL_CYCLES  = 3'h4;
	localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
	localparam int unsigned WRITE_OSC_CYCLES  = 27072;

	localparam logic [ADDR_BITS-1:0] ADDR_RESET = 9'h000;
	localparam logic [DATA_BITS-1:0] DATA_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_BUSY   = 3'b010,
		ST_COMMIT = 3'b100
	} wr_state_type;

endpackage

// ==== rtl/nv_mem_if.sv ====
// byte array access port between the controller and its storage
// assumes: one clock; the array reads combinationally
`timescale 1ns/10ps
`default_nettype none
interface nv_mem_if
	import nv_ctrl_pkg::*;
	();
	logic [ADDR_BITS-1:0] addr;
	logic [DATA_BITS-1:0] wdata;
	logic                 we;
	logic [DATA_BITS-1:0] rdata;

	modport ctrl (output addr, output wdata, output we, input rdata);
	modport mem  (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ==== rtl/nv_byte_array.sv ====
// storage array of the nonvolatile data space, one byte per location
// assumes: write enable is a one-cycle pulse qualified by the clock enable
`timescale 1ns/10ps
`default_nettype none
module nv_byte_array
	import nv_ctrl_pkg::*;
#(
	parameter int unsigned DEPTH = MEM_BYTES
)(
	input  wire logic pclk,
	input  wire logic ce,
	nv_mem_if.mem     port
);

	logic [DATA_BITS-1:0] cells [DEPTH];

	// refused at elaboration: the address port cannot reach more cells
	if (DEPTH > (1 << ADDR_BITS))
	begin : g_depth_chk
		$error("depth exceeds the address range");
	end

	// no reset: contents are nonvolatile by nature
	always_ff @(posedge pclk)
	begin
		if (ce && port.we)
			cells[port.addr] <= port.wdata;
	end

	assign port.rdata = cells[port.addr];

endmodule
`default_nettype wire

// ==== rtl/nv_access_ctrl.sv ====
// byte-wide nonvolatile data store controller with apb register access
// assumes: apb master on pclk; rc oscillator tick from another domain;
// self-program busy level and global irq enable come from pclk logic
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module nv_access_ctrl
	import nv_ctrl_pkg::*;
#(
	parameter int unsigned OSC_COUNT = WRITE_OSC_CYCLES,
	parameter int unsigned OSC_CNT_W = 15
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rc_osc_clk,
	input  wire logic        self_program_busy,
	input  wire logic        global_irq_enable,
	output logic             cpu_stall,
	output logic             irq
);

	// refused at elaboration: the end count would be cut to the counter width, so the write timer would end at the wrong tick
	if (OSC_COUNT < 1 || OSC_COUNT >= (1 << OSC_CNT_W))
	begin : g_osc_chk
		$error("oscillator count does not fit its counter");
	end

	nv_mem_if mem_port ();

	nv_byte_array #(
		.DEPTH (MEM_BYTES)
	) u_array (
		.pclk (pclk),
		.ce   (ce),
		.port (mem_port)
	);

	logic [ADDR_BITS-1:0] nv_address_reg_q;
	logic [DATA_BITS-1:0] nv_data_reg_q;
	logic                 ready_irq_enable_q;
	logic                 eeprom_write_strobe_q;
	logic [2:0]           arm_cnt_q;
	logic                 master_write_arm;
	logic [2:0]           stall_cnt_q;
	logic [EVT_BITS-1:0]  status_q;
	logic [EVT_BITS-1:0]  irq_en_q;
	logic [EVT_BITS-1:0]  evt_set;
	logic [EVT_BITS-1:0]  evt_clr;
	logic [ADDR_BITS-1:0] wr_addr_q;
	logic [DATA_BITS-1:0] wr_data_q;
	logic [OSC_CNT_W-1:0] osc_cnt_q;
	wr_state_type         state_q;
	wr_state_type         state_d;
	logic                 osc_meta_q;
	logic                 osc_sync_q;
	logic                 osc_prev_q;
	logic                 osc_tick;
	logic                 loaded_q;
	logic                 access;
	logic                 wr_en;
	logic                 hit_ctrl;
	logic                 launch;
	logic                 read_go;
	logic                 arm_set;
	logic                 busy;
	logic                 ready_irq;
	logic [31:0]          rd_mux;
	logic                 rd_err;

	// apb: read data and error are latched in the setup cycle, so every
	// transfer completes with zero wait states while ce is high
	assign access = psel && penable && loaded_q;
	assign pready = ce && access;
	assign wr_en  = pready && pwrite;

	assign busy     = (state_q != ST_IDLE);
	assign hit_ctrl = wr_en && (paddr == OFS_CTRL);
	assign master_write_arm = (arm_cnt_q != 3'h0);
	assign arm_set  = hit_ctrl && pwdata[CTRL_ARM];
	// arm must already be standing; arm and strobe in one write fail
	assign launch   = hit_ctrl && pwdata[CTRL_WRITE] && master_write_arm
		&& !busy && !self_program_busy;
	assign read_go  = hit_ctrl && pwdata[CTRL_READ] && !busy;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
			OFS_CTRL:
			begin
				rd_mux[CTRL_RIE]   = ready_irq_enable_q;
				rd_mux[CTRL_ARM]   = master_write_arm;
				rd_mux[CTRL_WRITE] = eeprom_write_strobe_q;
			end
			OFS_ADDR:  rd_mux[ADDR_BITS-1:0] = nv_address_reg_q;
			OFS_DATA:  rd_mux[DATA_BITS-1:0] = nv_data_reg_q;
			OFS_STAT:  rd_mux[EVT_BITS-1:0]  = status_q;
			OFS_CLR:   rd_mux = 32'h0000_0000;
			OFS_IEN:   rd_mux[EVT_BITS-1:0]  = irq_en_q;
			OFS_FLAGS: rd_mux[FLAG_SPM_BUSY] = self_program_busy;
			default:   rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata   <= 32'h0000_0000;
			pslverr  <= 1'b0;
			loaded_q <= 1'b0;
		end
		else if (ce)
		begin
			if (psel && !penable)
			begin
				prdata   <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr  <= rd_err;
				loaded_q <= 1'b1;
			end
			else if (access)
				loaded_q <= 1'b0;
		end
	end

	// rc oscillator arrives asynchronously: two flops, then edge detect
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_meta_q <= 1'b0;
			osc_sync_q <= 1'b0;
			osc_prev_q <= 1'b0;
		end
		else if (ce)
		begin
			osc_meta_q <= rc_osc_clk;
			osc_sync_q <= osc_meta_q;
			osc_prev_q <= osc_sync_q;
		end
	end

	assign osc_tick = osc_sync_q && !osc_prev_q;

	// software registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			nv_address_reg_q   <= ADDR_RESET;
			ready_irq_enable_q <= 1'b0;
			irq_en_q           <= '0;
		end
		else if (ce)
		begin
			// address is frozen while a write is under way
			if (wr_en && paddr == OFS_ADDR && !busy)
				nv_address_reg_q <= pwdata[ADDR_BITS-1:0];
			if (hit_ctrl)
				ready_irq_enable_q <= pwdata[CTRL_RIE];
			if (wr_en && paddr == OFS_IEN)
				irq_en_q <= pwdata[EVT_BITS-1:0];
		end
	end

	// data register: software write or a completed read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			nv_data_reg_q <= DATA_RESET;
		else if (ce)
		begin
			if (read_go)
				nv_data_reg_q <= mem_port.rdata;
			else if (wr_en && paddr == OFS_DATA)
				nv_data_reg_q <= pwdata[DATA_BITS-1:0];
		end
	end

	// arm window
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			arm_cnt_q <= 3'h0;
		else if (ce)
		begin
			if (launch)
				arm_cnt_q <= 3'h0;
			else if (arm_set)
				arm_cnt_q <= ARM_CYCLES;
			else if (master_write_arm)
				arm_cnt_q <= arm_cnt_q - 3'h1;
		end
	end

	// core stall counter; a read outranks a launch when both arrive
	// in one control write while idle and armed, so the read length loads
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stall_cnt_q <= 3'h0;
		else if (ce)
		begin
			if (read_go)
				stall_cnt_q <= READ_STALL_CYCLES;
			else if (launch)
				stall_cnt_q <= WRITE_STALL_CYCLES;
			else if (stall_cnt_q != 3'h0)
				stall_cnt_q <= stall_cnt_q - 3'h1;
		end
	end

	assign cpu_stall = (stall_cnt_q != 3'h0);

	// write sequencer
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (launch)
					state_d = ST_BUSY;
			ST_BUSY:
				if (osc_tick && osc_cnt_q == OSC_CNT_W'(OSC_COUNT - 1))
					state_d = ST_COMMIT;
			ST_COMMIT:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= ST_IDLE;
		else if (ce)
			state_q <= state_d;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			osc_cnt_q <= '0;
		else if (ce)
		begin
			if (state_q != ST_BUSY)
				osc_cnt_q <= '0;
			else if (osc_tick)
				osc_cnt_q <= osc_cnt_q + OSC_CNT_W'(1);
		end
	end

	// address and data captured at launch so later data writes are safe
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_addr_q <= ADDR_RESET;
			wr_data_q <= DATA_RESET;
		end
		else if (ce && launch)
		begin
			wr_addr_q <= nv_address_reg_q;
			wr_data_q <= nv_data_reg_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			eeprom_write_strobe_q <= 1'b0;
		else if (ce)
		begin
			if (launch)
				eeprom_write_strobe_q <= 1'b1;
			else if (state_q == ST_COMMIT)
				eeprom_write_strobe_q <= 1'b0;
		end
	end

	assign mem_port.addr  = busy ? wr_addr_q : nv_address_reg_q;
	assign mem_port.wdata = wr_data_q;
	assign mem_port.we    = (state_q == ST_COMMIT);

	// sticky events; a new event wins over a clear in the same cycle
	always_comb
	begin
		evt_set = '0;
		evt_set[EVT_WRITE_DONE]  = (state_q == ST_COMMIT);
		evt_set[EVT_ARM_EXPIRED] = (arm_cnt_q == 3'h1) && !launch
			&& !arm_set;
		evt_set[EVT_READ_DONE]   = read_go;
		evt_clr = '0;
		if (wr_en && paddr == OFS_CLR)
			evt_clr = pwdata[EVT_BITS-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= '0;
		else if (ce)
			status_q <= (status_q & ~evt_clr) | evt_set;
	end

	assign ready_irq = ready_irq_enable_q && global_irq_enable
		&& !eeprom_write_strobe_q;
	assign irq = ready_irq || (|(status_q & irq_en_q));

endmodule
`default_nettype wire

// ==== sim/rc_osc_model.sv ====
// free running rc oscillator feeding the write timer
// assumes: phase unrelated to pclk
`timescale 1ns/10ps
`default_nettype none
module rc_osc_model #(
	parameter real HALF = 45.3
)(
	output var logic osc
);
	initial osc = 1'b0;
	always #(HALF) osc = ~osc;
endmodule
`default_nettype wire

// ==== sim/nv_access_checker.sv ====
// port checks of the nonvolatile store controller
// assumes: bound into nv_access_ctrl, one clock domain
`timescale 1ns/10ps
`default_nettype none
module nv_access_checker
	import nv_ctrl_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        self_program_busy,
	input wire logic        cpu_stall,
	input wire logic        irq
);
	logic acc;
	logic ctl;
	assign acc = psel && penable && pready;
	assign ctl = acc && pwrite && paddr == OFS_CTRL;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		ce && psel && !penable;
	endsequence
	sequence access_s;
		ce && psel && penable;
	endsequence
	ready_wait_a: assert property (setup_s ##1 access_s |-> pready)
		else $error("ready missing");
	// irq high here stands for ready enable set and no write busy
	read_stall_a: assert property (ctl && pwdata[3:0] == 4'h9 && irq
		|=> cpu_stall[*4] ##1 !cpu_stall)
		else $error("read stall wrong");
	stall_len_a: assert property ($rose(cpu_stall) |-> cpu_stall[*2]
		##1 (!cpu_stall or cpu_stall[*2] ##1 !cpu_stall))
		else $error("stall length wrong");
	stall_cause_a: assert property ($rose(cpu_stall) |-> $past(ctl))
		else $error("stall without control write");
	spm_block_a: assert property (ctl && pwdata[1:0] == 2'b10
		&& self_program_busy && !cpu_stall |=> !cpu_stall)
		else $error("write launched while flash busy");
	slv_err_a: assert property (acc |-> pslverr ==
		(paddr > OFS_FLAGS || paddr[1:0] != 2'b00))
		else $error("slave error wrong");
	write_zero_a: assert property (acc && pwrite |-> prdata == 32'h0)
		else $error("read data on write");
	hold_data_a: assert property (acc ##1 !psel |-> $stable(prdata))
		else $error("read data moved");
endmodule
bind nv_access_ctrl nv_access_checker nv_access_checker_i (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.self_program_busy(self_program_busy), .cpu_stall(cpu_stall),
	.irq(irq));
`default_nettype wire

// ==== sim/tb_top.sv ====
// apb bench of the nonvolatile store controller
// assumes: rc oscillator model beside it; ce low only in the freeze test
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import nv_ctrl_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, self_program_busy = 1'b0;
	logic        global_irq_enable = 1'b1, ce = 1'b1;
	logic        rc_osc_clk, pready, pslverr, cpu_stall, irq, rs;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rq;
	logic [8:0]  ads [3] = '{9'h000, 9'h1ff, 9'h0a5};
	int          bad_count = 0, checks_done = 0;
	// short write timer so a busy period spans only a few transfers
	nv_access_ctrl #(.OSC_COUNT(4)) nv_access_ctrl_i (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rc_osc_clk(rc_osc_clk), .self_program_busy(self_program_busy),
		.global_irq_enable(global_irq_enable), .cpu_stall(cpu_stall),
		.irq(irq));
	rc_osc_model rc_osc_model_i (.osc(rc_osc_clk));
	always #5 pclk = ~pclk;
	task automatic cmp(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("BAD %s exp %h got %h", n, e, g);
			bad_count++;
		end
	endtask
	// looks just after the rising edge, before that edge's updates land,
	// so pready and prdata are the values the edge itself sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rq = prdata;
		rs = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) cmp("pready", 32'h1, 32'h0);
	endtask
	task automatic stall_is(input int e);
		int n;
		n = 0;
		repeat (8)
		begin
			@(posedge pclk);
			if (cpu_stall === 1'b1)
				n++;
		end
		cmp("stall cycles", 32'(e), 32'(n));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic ck(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp($sformatf("reg %h", a), e, rq);
	endtask
	task automatic launch(input logic [8:0] a, input logic [7:0] d);
		wr(OFS_ADDR, 32'(a));
		wr(OFS_DATA, 32'(d));
		wr(OFS_CTRL, 32'h4);
		wr(OFS_CTRL, 32'h2);
		stall_is(2);
		bus(1'b0, OFS_CTRL, 32'h0);
		cmp("strobe set", 32'h1, 32'(rq[CTRL_WRITE]));
	endtask
	task automatic idle;
		int n;
		n = 0;
		do
		begin
			bus(1'b0, OFS_CTRL, 32'h0);
			n++;
		end
		while (rq[CTRL_WRITE] !== 1'b0 && n < 200);
		cmp("strobe clear", 32'h0, 32'(rq[CTRL_WRITE]));
	endtask
	task automatic irq_is(input logic e);
		@(posedge pclk);
		cmp("irq", 32'(e), 32'(irq));
	endtask
	task automatic complete_run;
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		ck(OFS_ADDR, 32'h0);
		ck(OFS_DATA, 32'h0);
		$display("test reset done");
		foreach (ads[i])
		begin
			launch(ads[i], ads[i][7:0] ^ 8'h5a);
			idle;
		end
		foreach (ads[i])
		begin
			wr(OFS_ADDR, 32'(ads[i]));
			wr(OFS_CTRL, 32'h9);
			stall_is(4);
			ck(OFS_DATA, 32'(ads[i][7:0] ^ 8'h5a));
		end
		$display("test write read done");
		launch(9'h003, 8'h77);
		wr(OFS_ADDR, 32'h1ff);
		wr(OFS_CTRL, 32'h1);
		ck(OFS_ADDR, 32'h3);
		ck(OFS_DATA, 32'h77);
		idle;
		wr(OFS_DATA, 32'h0);
		wr(OFS_CTRL, 32'h1);
		ck(OFS_DATA, 32'h77);
		$display("test busy done");
		wr(OFS_CTRL, 32'h4);
		ck(OFS_CTRL, 32'h4);
		repeat (4) @(posedge pclk);
		ck(OFS_CTRL, 32'h0);
		wr(OFS_CTRL, 32'h2);
		ck(OFS_CTRL, 32'h0);
		ck(OFS_STAT, 32'h7);
		self_program_busy <= 1'b1;
		ck(OFS_FLAGS, 32'h1);
		wr(OFS_CTRL, 32'h4);
		wr(OFS_CTRL, 32'h2);
		stall_is(0);
		bus(1'b0, OFS_CTRL, 32'h0);
		cmp("blocked", 32'h0, 32'(rq[CTRL_WRITE]));
		self_program_busy <= 1'b0;
		// arm window frozen while ce is low, so it outlives six cycles
		wr(OFS_CTRL, 32'h4);
		ce <= 1'b0;
		repeat (6) @(posedge pclk);
		ce <= 1'b1;
		ck(OFS_CTRL, 32'h4);
		$display("test arm done");
		wr(OFS_CLR, 32'h7);
		ck(OFS_STAT, 32'h0);
		wr(OFS_IEN, 32'h1);
		launch(9'h005, 8'h33);
		idle;
		irq_is(1'b1);
		wr(OFS_IEN, 32'h0);
		irq_is(1'b0);
		wr(OFS_CLR, 32'h1);
		ck(OFS_STAT, 32'h0);
		wr(OFS_CTRL, 32'h8);
		irq_is(1'b1);
		global_irq_enable <= 1'b0;
		irq_is(1'b0);
		bus(1'b1, 8'h1c, 32'hff);
		cmp("slverr", 32'h1, 32'(rs));
		ck(8'h1c, 32'h0);
		$display("test irq map done");
		complete_run;
	end
	initial
	begin
		#100us;
		bad_count++;
		complete_run;
	end
endmodule
`default_nettype wire
